// ===== hdl/ptpb_builder.sv
// Pixel thread payload builder for contiguous 32 and 64 pixel dispatch.
// ----------------------------------------------------------------------
// Summary of operation
// - Header carries 4-bit scratch size code, 0..11.
// - Scratch code forwarded unchanged, never interpreted.
// - 32-pixel mode: mask word 0 lit bits.
// - 64-pixel: mask0 lower half, mask1 upper half.
// - Mask bits map to 8x4 area by quads.
// - Block upper-left X, Y as unsigned words.
// - Start vertex X, Y as float words.
// - Gap before buffer data is reserved padding.
// - Buffer data starts at programmed register index, but not before R2.
// - Constant data read at offset, length, after header.
// - Setup coefficients from handle's entry, at end.
// - Coefficient register holds two attributes, X Y - O.
// - Count unmasked pixels dispatched when statistics enabled.
// - Early depth discards are still counted.
// ----------------------------------------------------------------------
module ptpb_builder
    import ptpb_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire ptpb_obj_t    obj,
    input  wire logic         obj_valid,
    output logic              obj_ready,
    input  wire ptpb_cfg_t    cfg,
    output ptpb_rd_req_t      rd_req,
    output logic              rd_req_valid,
    input  wire logic         rd_req_ready,
    input  wire logic [REG_W-1:0] rd_data,
    input  wire logic         rd_data_valid,
    output ptpb_wr_t          wr,
    output logic              wr_valid,
    input  wire logic         wr_ready,
    output logic              dispatch,
    output logic [CNT_W-1:0]  shader_invocation_counter
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        ptpb_state_t       st;
        ptpb_obj_t         obj;
        ptpb_cfg_t         cfg;
        logic [RIDX_W-1:0] idx;       // Next register index to write.
        logic [LEN_W-1:0]  cnt;       // Registers left in current section.
        logic              req_out;   // Read request outstanding.
        logic              obj_ready;
        ptpb_rd_req_t      rd_req;
        logic              rd_req_valid;
        logic              dispatch;
        logic [CNT_W-1:0]  inv_cnt;
        ptpb_wr_t          b0;        // Two-entry output buffer, head.
        logic              b0_v;
        ptpb_wr_t          b1;
        logic              b1_v;
        ptpb_wr_t          wr;
        logic              wr_valid;
    } ptpb_regs_t;

    ptpb_regs_t r_r;
    ptpb_regs_t r_nxt;

    // Pixel count of the dispatch, from the masks only.
    function automatic logic [6:0] ptpb_popcount(input logic [63:0] v);
        logic [6:0] s;
        s = 7'h00;
        for (int i = 0; i < 64; i++) begin
            s = s + {6'h00, v[i]};
        end
        return s;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic              push;
        ptpb_wr_t          pw;
        logic [REG_W-1:0]  hdr;
        logic [63:0]       lit;
        logic              room;
        logic              pop;
        r_nxt = r_r;
        push  = 1'b0;
        pw    = '0;
        hdr   = '0;
        lit   = '0;
        r_nxt.dispatch = 1'b0;
        // The buffer pops whenever the receiver accepts the output word.
        pop  = r_r.wr_valid && wr_ready;
        room = !r_r.b1_v;  // Producer stalls while the second slot is full.
        if (r_r.rd_req_valid && rd_req_ready) begin
            r_nxt.rd_req_valid = 1'b0;
        end

        unique case (r_r.st)
            PT_IDLE: begin
                r_nxt.obj_ready = 1'b1;
                if (obj_valid && r_r.obj_ready) begin
                    r_nxt.obj       = obj;
                    r_nxt.cfg       = cfg;
                    r_nxt.idx       = '0;
                    r_nxt.obj_ready = 1'b0;
                    r_nxt.st        = PT_HDR;
                end
            end
            PT_HDR: begin
                if (room) begin
                    if (r_r.idx == '0) begin
                        // Scratch code is passed through verbatim.
                        hdr[R0_SCRATCH*DW_W +: 4] = r_r.obj.scratch_code;
                        hdr[R0_MASK0*DW_W +: DW_W]   = r_r.obj.mask0;
                        hdr[R0_BLOCK_Y*DW_W +: DW_W] = r_r.obj.block_y;
                        hdr[R0_BLOCK_X*DW_W +: DW_W] = r_r.obj.block_x;
                    end else begin
                        // Second mask is reserved zero in 32-pixel mode.
                        hdr[R1_MASK1*DW_W +: DW_W] = r_r.obj.dispatch64 ? r_r.obj.mask1 : '0;
                        hdr[R1_START_Y*DW_W +: DW_W] = r_r.obj.start_y;
                        hdr[R1_START_X*DW_W +: DW_W] = r_r.obj.start_x;
                    end
                    push     = 1'b1;
                    pw.index = r_r.idx;
                    pw.data  = hdr;
                    r_nxt.idx = r_r.idx + 7'h01;
                    if (r_r.idx == 7'(HDR_REGS - 1)) begin
                        r_nxt.st = PT_PAD;
                    end
                end
            end
            PT_PAD: begin
                // Zero registers fill up to the programmed start.
                if (r_r.idx < r_r.cfg.data_start) begin
                    if (room) begin
                        push      = 1'b1;
                        pw.index  = r_r.idx;
                        r_nxt.idx = r_r.idx + 7'h01;
                    end
                end else begin
                    r_nxt.st  = PT_CONST;
                    r_nxt.cnt = r_r.cfg.const_len;
                end
            end
            PT_CONST, PT_SETUP: begin
                if (r_r.cnt == '0) begin
                    if (r_r.st == PT_CONST) begin
                        r_nxt.st  = PT_SETUP;
                        r_nxt.cnt = r_r.cfg.setup_len;
                    end else begin
                        r_nxt.st = PT_DONE;
                    end
                end else if (!r_r.req_out && room) begin
                    // One register is fetched at a time, so writes stay ordered.
                    r_nxt.req_out      = 1'b1;
                    r_nxt.rd_req_valid = 1'b1;
                    if (r_r.st == PT_CONST) begin
                        r_nxt.rd_req.entry  = ENT_CONST;
                        r_nxt.rd_req.handle = '0;
                        r_nxt.rd_req.offset = r_r.cfg.const_off + (r_r.cfg.const_len - r_r.cnt);
                    end else begin
                        r_nxt.rd_req.entry  = ENT_SETUP;
                        r_nxt.rd_req.handle = r_r.obj.setup_handle;
                        r_nxt.rd_req.offset = r_r.cfg.setup_off + (r_r.cfg.setup_len - r_r.cnt);
                    end
                end else if (r_r.req_out && rd_data_valid && !r_r.rd_req_valid) begin
                    // Coefficient layout is carried as read.
                    push          = 1'b1;
                    pw.index      = r_r.idx;
                    pw.data       = rd_data;
                    r_nxt.req_out = 1'b0;
                    r_nxt.idx     = r_r.idx + 7'h01;
                    r_nxt.cnt     = r_r.cnt - 6'h01;
                end
            end
            PT_DONE: begin
                // Dispatch only after the last register has drained.
                if (!r_r.b0_v && !r_r.b1_v && !r_r.wr_valid) begin
                    r_nxt.dispatch = 1'b1;
                    lit = {r_r.obj.dispatch64 ? r_r.obj.mask1 : 32'h0000_0000, r_r.obj.mask0};
                    // Early depth discards happen later, so they are counted.
                    if (r_r.cfg.stats_en) begin
                        r_nxt.inv_cnt = r_r.inv_cnt + {57'h0, ptpb_popcount(lit)};
                    end
                    r_nxt.st = PT_IDLE;
                end
            end
            default: r_nxt.st = PT_IDLE;
        endcase

        // Two-entry buffer: the output register is fed from the head slot.
        if (pop || !r_r.wr_valid) begin
            r_nxt.wr_valid = r_r.b0_v;
            r_nxt.wr       = r_r.b0;
            r_nxt.b0       = r_r.b1;
            r_nxt.b0_v     = r_r.b1_v;
            r_nxt.b1_v     = 1'b0;
            if (push) begin
                if (r_r.b1_v) begin
                    r_nxt.b1   = pw;
                    r_nxt.b1_v = 1'b1;
                end else begin
                    r_nxt.b0   = r_r.b0_v ? r_r.b0 : pw;
                    r_nxt.b0_v = 1'b1;
                    if (r_r.b0_v) begin
                        r_nxt.b0   = pw;
                    end
                end
            end
        end else if (push) begin
            if (r_r.b0_v) begin
                r_nxt.b1   = pw;
                r_nxt.b1_v = 1'b1;
            end else begin
                r_nxt.b0   = pw;
                r_nxt.b0_v = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs straight from flip-flops
    // ------------------------------------------------------------------
    assign obj_ready                 = r_r.obj_ready;
    assign rd_req                    = r_r.rd_req;
    assign rd_req_valid              = r_r.rd_req_valid;
    assign wr                        = r_r.wr;
    assign wr_valid                  = r_r.wr_valid;
    assign dispatch                  = r_r.dispatch;
    assign shader_invocation_counter = r_r.inv_cnt;

endmodule

// ===== hdl/ptpb_pkg.sv
// Package of constants and carrier types for the pixel thread payload builder.
package ptpb_pkg;

    // ------------------------------------------------------------------
    // Payload geometry
    // ------------------------------------------------------------------
    localparam int unsigned DW_W        = 32;
    localparam int unsigned REG_DW      = 8;     // Dwords in one payload register.
    localparam int unsigned REG_W       = DW_W * REG_DW;
    localparam int unsigned RIDX_W      = 7;     // Payload register index width.
    localparam int unsigned LEN_W       = 6;     // Read lengths in 8-dword registers.
    localparam int unsigned HDR_REGS    = 2;     // R0 and R1 are always sent.
    localparam logic [3:0]  SCRATCH_MAX = 4'hB;  // Highest legal scratch size code.
    localparam int unsigned CNT_W       = 64;

    // Dword slots inside the header registers.
    localparam int unsigned R0_SCRATCH  = 5;
    localparam int unsigned R0_MASK0    = 2;
    localparam int unsigned R0_BLOCK_Y  = 1;
    localparam int unsigned R0_BLOCK_X  = 0;
    localparam int unsigned R1_MASK1    = 2;
    localparam int unsigned R1_START_Y  = 1;
    localparam int unsigned R1_START_X  = 0;

    // Dword slots inside one coefficient register.
    localparam int unsigned CF_X0 = 0;
    localparam int unsigned CF_Y0 = 1;
    localparam int unsigned CF_O0 = 3;
    localparam int unsigned CF_X1 = 4;
    localparam int unsigned CF_Y1 = 5;
    localparam int unsigned CF_O1 = 7;

    // Return buffer entry selectors.
    localparam logic ENT_CONST = 1'b0;
    localparam logic ENT_SETUP = 1'b1;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0]      scratch_code;
        logic            dispatch64;
        logic [31:0]     mask0;
        logic [31:0]     mask1;
        logic [31:0]     block_x;
        logic [31:0]     block_y;
        logic [31:0]     start_x;
        logic [31:0]     start_y;
        logic [15:0]     setup_handle;
    } ptpb_obj_t;

    typedef struct packed {
        logic [RIDX_W-1:0] data_start;
        logic [LEN_W-1:0]  const_off;
        logic [LEN_W-1:0]  const_len;
        logic [LEN_W-1:0]  setup_off;
        logic [LEN_W-1:0]  setup_len;
        logic              stats_en;
        logic              early_depth_en;
    } ptpb_cfg_t;

    typedef struct packed {
        logic              entry;
        logic [15:0]       handle;
        logic [LEN_W-1:0]  offset;
    } ptpb_rd_req_t;

    typedef struct packed {
        logic [RIDX_W-1:0] index;
        logic [REG_W-1:0]  data;
        logic              last;
    } ptpb_wr_t;

    typedef enum logic [2:0] {
        PT_IDLE  = 3'b000,
        PT_HDR   = 3'b001,
        PT_PAD   = 3'b011,
        PT_CONST = 3'b010,
        PT_SETUP = 3'b110,
        PT_DONE  = 3'b111
    } ptpb_state_t;

endpackage

// ===== tb/ptpb_builder_props.sv
// Checker of the payload builder's port timing, bound to the design.
module ptpb_builder_props
    import ptpb_pkg::*;
(
    input wire logic             clk,
    input wire logic             rstn,
    input wire logic             obj_valid,
    input wire logic             obj_ready,
    input wire ptpb_rd_req_t     rd_req,
    input wire logic             rd_req_valid,
    input wire logic             rd_req_ready,
    input wire ptpb_wr_t         wr,
    input wire logic             wr_valid,
    input wire logic             wr_ready,
    input wire logic             dispatch,
    input wire logic [CNT_W-1:0] shader_invocation_counter
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------------
    // Next expected register index, restarted by every dispatch.
    // ------------------------------------------------------------------
    logic [RIDX_W-1:0] idx_r;
    logic              seen_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idx_r  <= '0;
            seen_r <= 1'b0;
        end else if (dispatch) begin
            seen_r <= 1'b0;
        end else if (wr_valid && wr_ready) begin
            idx_r  <= wr.index + 1'b1;
            seen_r <= 1'b1;
        end
    end
    wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr))
        else $error("write dropped or changed before it was taken");
    rd_hold_a: assert property (
        rd_req_valid && !rd_req_ready |=> rd_req_valid && $stable(rd_req))
        else $error("read request dropped or changed before it was taken");
    first_reg_a: assert property (wr_valid && !seen_r |-> wr.index == '0)
        else $error("payload does not open with register zero");
    next_reg_a: assert property (wr_valid && seen_r |-> wr.index == idx_r)
        else $error("payload register index skipped or repeated");
    hdr_soon_a: assert property (
        obj_valid && obj_ready |-> ##[1:8] (wr_valid && wr.index == '0))
        else $error("header not offered soon after accept");
    busy_refuse_a: assert property (obj_valid && obj_ready |=> !obj_ready)
        else $error("new object accepted while busy");
    disp_pulse_a: assert property (
        dispatch |-> !wr_valid && !rd_req_valid ##1 !dispatch)
        else $error("dispatch with work pending or longer than one cycle");
    cnt_only_a: assert property (
        $changed(shader_invocation_counter) |-> dispatch || $past(dispatch))
        else $error("counter moved without a dispatch");
    cover property (dispatch);
    cover property (obj_valid && obj_ready);
    cover property (wr_valid && !wr_ready);
    cover property (rd_req_valid && !rd_req_ready);
endmodule

bind ptpb_builder ptpb_builder_props u_props (.clk(clk), .rstn(rstn), .obj_valid(obj_valid),
    .obj_ready(obj_ready), .rd_req(rd_req), .rd_req_valid(rd_req_valid),
    .rd_req_ready(rd_req_ready), .wr(wr), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .dispatch(dispatch), .shader_invocation_counter(shader_invocation_counter));

// ===== tb/ptpb_far_end.sv
// Model of the return buffer and of the thread's register write port.
module ptpb_far_end
    import ptpb_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         slow,
    input  wire ptpb_rd_req_t rd_req,
    input  wire logic         rd_req_valid,
    output logic              rd_req_ready,
    output logic [REG_W-1:0]  rd_data,
    output logic              rd_data_valid,
    output logic              wr_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    ptpb_rd_req_t q_r;
    logic         pend_r;
    // One read at a time; when slow, both ports stall at random.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_req_ready  <= 1'b0;
            rd_data_valid <= 1'b0;
            rd_data       <= '0;
            wr_ready      <= 1'b0;
            pend_r        <= 1'b0;
            q_r           <= '0;
        end else begin
            wr_ready      <= !slow || $urandom_range(1, 0) == 1;
            rd_data_valid <= 1'b0;
            rd_data       <= ~rd_data; // Stale data toggles so nothing can lean on it.
            if (rd_req_valid && rd_req_ready) begin
                q_r          <= rd_req;
                pend_r       <= 1'b1;
                rd_req_ready <= 1'b0;
            end else if (pend_r && (!slow || $urandom_range(1, 0) == 1)) begin
                pend_r        <= 1'b0;
                rd_data_valid <= 1'b1;
                rd_data       <= {8{7'h00, q_r.entry, q_r.handle, 2'h0, q_r.offset}};
            end else begin
                rd_req_ready <= !pend_r;
            end
        end
    end
endmodule

// ===== tb/tb_ptpb_builder.sv
// Self-checking bench of the payload builder with random objects.
module tb_ptpb_builder;
    import ptpb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, obj_valid, obj_ready, slow, rd_req_valid, rd_req_ready;
    logic rd_data_valid, wr_valid, wr_ready, dispatch;
    ptpb_obj_t obj;
    ptpb_cfg_t cfg;
    ptpb_rd_req_t rd_req;
    ptpb_wr_t wr;
    ptpb_wr_t q[$];
    logic [REG_W-1:0] rd_data;
    logic [CNT_W-1:0] cnt, exp_cnt;
    int errors, n_tests;
    ptpb_builder dut (.clk(clk), .rstn(rstn), .obj(obj), .obj_valid(obj_valid),
        .obj_ready(obj_ready), .cfg(cfg), .rd_req(rd_req), .rd_req_valid(rd_req_valid),
        .rd_req_ready(rd_req_ready), .rd_data(rd_data), .rd_data_valid(rd_data_valid),
        .wr(wr), .wr_valid(wr_valid), .wr_ready(wr_ready), .dispatch(dispatch),
        .shader_invocation_counter(cnt));
    ptpb_far_end rb (.clk(clk), .rstn(rstn), .slow(slow), .rd_req(rd_req),
        .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready), .rd_data(rd_data),
        .rd_data_valid(rd_data_valid), .wr_ready(wr_ready));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Every register taken by the thread is logged for the end-of-payload check.
    always @(posedge clk) if (wr_valid && wr_ready) q.push_back(wr);
    task automatic chk(string what, logic [REG_W-1:0] exp, logic [REG_W-1:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [DW_W-1:0] fill(logic e, logic [15:0] h, logic [LEN_W-1:0] off);
        return {7'h00, e, h, 2'h0, off};
    endfunction
    task automatic wrap_up;
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Offers one object, waits for its dispatch, then checks the whole payload.
    task automatic run_one(ptpb_obj_t o, ptpb_cfg_t c);
        int n, s, k;
        logic [REG_W-1:0] e;
        obj <= o;
        cfg <= c;
        obj_valid <= 1'b1;
        q.delete();
        n = 0;
        do begin @(posedge clk); n++; end while (!obj_ready && n < 50);
        // A limit that runs out shows up here as a mismatch.
        chk("accept", REG_W'(1'b1), REG_W'(obj_ready));
        obj_valid <= 1'b0;
        n = 0;
        do begin @(posedge clk); n++; end while (!dispatch && n < 500);
        chk("dispatch", REG_W'(1'b1), REG_W'(dispatch));
        @(posedge clk);
        if (c.stats_en) exp_cnt += $countones(o.mask0) + (o.dispatch64 ? $countones(o.mask1) : 0);
        chk("counter", REG_W'(exp_cnt), REG_W'(cnt));
        s = (c.data_start < 2) ? 2 : c.data_start;
        chk("length", REG_W'(s + c.const_len + c.setup_len), REG_W'(q.size()));
        for (k = 0; k < q.size(); k++) begin
            chk("index", REG_W'(k), REG_W'(q[k].index));
            if (k == 0) begin
                e = REG_W'({o.mask0, o.block_y, o.block_x});
                chk("header0", e, REG_W'(q[k].data[95:0]));
                e = REG_W'(o.scratch_code);
                chk("scratch", e, REG_W'(q[k].data[32*R0_SCRATCH +: 4]));
            end else if (k == 1) begin
                e = REG_W'({o.dispatch64 ? o.mask1 : 32'h0, o.start_y, o.start_x});
                chk("header1", e, REG_W'(q[k].data[95:0]));
            end else if (k < s) begin
                chk("padding", '0, q[k].data);
            end else if (k < s + c.const_len) begin
                // The whole register is compared, handle field included.
                e = {8{fill(ENT_CONST, 16'h0000, LEN_W'(c.const_off + k - s))}};
                chk("constant", e, q[k].data);
            end else begin
                e = {8{fill(ENT_SETUP, o.setup_handle,
                    LEN_W'(c.setup_off + k - s - c.const_len))}};
                chk("setup", e, q[k].data);
            end
        end
    endtask
    // The bound covers some 30 payloads of at most a few hundred cycles each.
    initial begin
        #(20000 * 10);
        errors++;
        wrap_up();
    end
    initial begin
        logic [223:0] r;
        ptpb_obj_t o;
        ptpb_cfg_t c;
        int i;
        errors = 0;
        n_tests = 0;
        exp_cnt = '0;
        rstn = 1'b0;
        obj_valid = 1'b0;
        obj = '0;
        cfg = '0;
        slow = 1'b0;
        void'($urandom(32'h6E99));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        for (i = 0; i < 30; i++) begin
            r = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
            o = r[$bits(ptpb_obj_t)-1:0];
            c = r[$bits(ptpb_cfg_t)-1:0];
            o.scratch_code = 4'($urandom_range(11, 0));
            c.data_start = 7'($urandom_range(6, 0));
            c.const_len = 6'($urandom_range(3, 0));
            c.setup_len = 6'($urandom_range(3, 0));
            // Corner cases: full 64-pixel masks with nothing read, then deep padding.
            if (i == 0) begin
                {o.mask0, o.mask1, o.dispatch64, c.stats_en, c.early_depth_en} = '1;
                {c.data_start, c.const_len, c.setup_len} = '0;
            end
            if (i == 1) begin
                c.data_start = 7'h09;
                c.const_len = 6'h03;
                c.setup_len = 6'h03;
            end
            slow <= i[0];
            run_one(o, c);
        end
        wrap_up();
    end
endmodule
